// ### ncf_top.sv
// ncf_top: calibration and feature command interpreter of a flash target
// Contract
// - F9h plus LUN cycle starts long calibration
// - long calibration accepted whenever target is ready
// - converged results loaded into drive impedance
// - long calibration finishes inside long window
// - failure reported in status fail bit
// - failed calibration falls back to preset impedance
// - reset aborts calibration, factory impedance restored
// - D9h plus LUN cycle starts short calibration
// - short failure sets fail bit, uses fallback
// - parameters travel on low eight data lines
// - feature write: command, address, four parameters
// - double rate writes: keep one copy each
// - timing mode write busy for interface-change time
// - D5h writes only the addressed LUN
// - LUN cycle carries binary LUN number
// - feature read returns current stored settings
// - double rate reads: each byte shown twice
// - 00h after status polling resumes at P1
// - D4h reads only the addressed LUN
// - feature addresses decode to fixed storage slots
// - feature settings volatile, cleared at power-up
`timescale 1ns/1ps
module ncf_top #(
  parameter int NUM_LUNS = 4,
  parameter int LUN_W    = 2
) (
  // clock and reset
  input  wire logic       CLK_SYS,
  input  wire logic       NRST,
  // flash bus pins from the host
  input  wire logic       CLE,
  input  wire logic       ALE,
  input  wire logic       WE_N,
  input  wire logic       RE_N,
  input  wire logic [7:0] DQ_IN,
  output logic      [7:0] DQ_OUT,
  output logic            DQ_OE,
  output logic            RB_N,
  // calibration engine
  output logic            CAL_START,
  input  wire logic       CAL_DONE,
  input  wire logic       CAL_FAIL,
  input  wire logic [7:0] CAL_CODE,
  // impedance to the I/O circuitry
  output logic      [7:0] DRIVE_IMP,
  output logic            CAL_BUSY
);

  // ==========================================================
  // feature address to storage slot, used by write and read paths
  function automatic logic [2:0] fidx(input logic [7:0] fa);
    if (fa == ncf_pkg::FA_TIMING)       fidx = 3'h0;
    else if (fa == ncf_pkg::FA_DDR_CFG) fidx = 3'h1;
    else if (fa == ncf_pkg::FA_DRIVE)   fidx = 3'h2;
    else if (fa == ncf_pkg::FA_TRAIN_A) fidx = 3'h3;
    else if (fa == ncf_pkg::FA_TRAIN_B) fidx = 3'h4;
    else if (fa == ncf_pkg::FA_VPP)     fidx = 3'h5;
    else if (fa == ncf_pkg::FA_VOLUME)  fidx = 3'h6;
    else                                fidx = ncf_pkg::FIDX_NONE;
  endfunction

  // ==========================================================
  // reset release and pin synchronisers
  logic                 rst_s1_reg;
  logic                 rst_n;
  logic [1:0]           cle_sy_reg, ale_sy_reg, we_sy_reg, re_sy_reg;
  logic [7:0]           dq_s1_reg, dq_s2_reg;
  logic                 we_d_reg, re_d_reg;

  // reset is released through two flops
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      rst_s1_reg <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n      <= rst_s1_reg;
    end
  end

  // pins come from the host's timing, so two flops before any use
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      cle_sy_reg <= 2'h0;
      ale_sy_reg <= 2'h0;
      we_sy_reg  <= 2'h3;
      re_sy_reg  <= 2'h3;
      dq_s1_reg  <= 8'h00;
      dq_s2_reg  <= 8'h00;
      we_d_reg   <= 1'b1;
      re_d_reg   <= 1'b1;
    end else begin
      cle_sy_reg <= {cle_sy_reg[0], CLE};
      ale_sy_reg <= {ale_sy_reg[0], ALE};
      we_sy_reg  <= {we_sy_reg[0], WE_N};
      re_sy_reg  <= {re_sy_reg[0], RE_N};
      dq_s1_reg  <= DQ_IN;
      dq_s2_reg  <= dq_s1_reg;
      we_d_reg   <= we_sy_reg[1];
      re_d_reg   <= re_sy_reg[1];
    end
  end

  // ==========================================================
  // decoded bus cycles
  ncf_pkg::ncf_cycle_type cyc;
  ncf_pkg::ncf_state_type state_reg;
  ncf_pkg::ncf_out_type   out_reg;
  logic [7:0]             cmd_reg, fa_reg;
  logic [LUN_W-1:0]       lun_reg;
  logic [1:0]             pidx_reg, ridx_reg;
  logic                   whalf_reg, rhalf_reg;
  logic [23:0]            pbuf_reg;
  logic [15:0]            busy_cnt_reg;
  logic                   cal_on_reg, got_reg, fail_reg;
  logic [7:0]             feat_mem [NUM_LUNS][ncf_pkg::NUM_FEAT][4];
  logic                   wr_stb, re_rise, cmd_stb, adr_stb, dat_stb;
  logic                   is_cal, is_get, lun_ok, ddr, go_cal, go_long;
  logic                   feat_wr, busy_end, abort, skip_copy;
  logic [LUN_W-1:0]       rd_lun;
  logic [2:0]             rd_fidx;
  logic [7:0]             rdata, status;

  // data is sampled on the rising write strobe, low lane only
  assign cyc       = '{cle: cle_sy_reg[1], ale: ale_sy_reg[1],
                       data: dq_s2_reg};
  assign wr_stb    = we_sy_reg[1] & ~we_d_reg;
  assign re_rise   = re_sy_reg[1] & ~re_d_reg;
  assign cmd_stb   = wr_stb & cyc.cle & ~cyc.ale;
  assign adr_stb   = wr_stb & cyc.ale & ~cyc.cle;
  assign dat_stb   = wr_stb & ~cyc.cle & ~cyc.ale;
  assign is_cal    = (cmd_reg == ncf_pkg::CMD_CAL_LONG) |
                     (cmd_reg == ncf_pkg::CMD_CAL_SHORT);
  assign is_get    = (cmd_reg == ncf_pkg::CMD_GET_TGT) |
                     (cmd_reg == ncf_pkg::CMD_GET_LUN);
  assign lun_ok    = cyc.data < 8'(NUM_LUNS);
  assign ddr       = feat_mem[0][ncf_pkg::FIDX_TIMING][0]
                     [ncf_pkg::IFACE_LSB +: 2] != 2'b00;
  assign go_cal    = adr_stb & (state_reg == ncf_pkg::ST_LUN) & is_cal
                     & lun_ok;
  assign go_long   = go_cal & (cmd_reg == ncf_pkg::CMD_CAL_LONG);
  assign skip_copy = ddr & whalf_reg;
  assign feat_wr   = dat_stb & (state_reg == ncf_pkg::ST_PARAM)
                     & ~skip_copy & (pidx_reg == 2'h3);
  assign busy_end  = (state_reg == ncf_pkg::ST_BUSY) &
                     (busy_cnt_reg == 16'h0001);
  assign abort     = cmd_stb & (cyc.data == ncf_pkg::CMD_RESET);
  assign rd_lun    = (cmd_reg == ncf_pkg::CMD_GET_LUN) ? lun_reg : '0;
  assign rd_fidx   = fidx(fa_reg);
  // unsupported and vendor addresses read back as zero
  assign rdata     = (rd_fidx == ncf_pkg::FIDX_NONE) ? 8'h00 :
                     feat_mem[rd_lun][rd_fidx][ridx_reg];
  always_comb begin
    status = 8'h00;
    status[ncf_pkg::STAT_RDY_BIT]  = (state_reg != ncf_pkg::ST_BUSY);
    status[ncf_pkg::STAT_ARDY_BIT] = (state_reg != ncf_pkg::ST_BUSY);
    status[ncf_pkg::STAT_FAIL_BIT] = fail_reg;
  end

  // ==========================================================
  // command sequencer and busy timer
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      state_reg    <= ncf_pkg::ST_IDLE;
      out_reg      <= ncf_pkg::OUT_NONE;
      cmd_reg      <= 8'h00;
      fa_reg       <= 8'h00;
      lun_reg      <= '0;
      pidx_reg     <= 2'h0;
      ridx_reg     <= 2'h0;
      whalf_reg    <= 1'b0;
      rhalf_reg    <= 1'b0;
      pbuf_reg     <= 24'h000000;
      busy_cnt_reg <= 16'h0000;
    end else if (abort) begin
      state_reg    <= ncf_pkg::ST_IDLE;
      out_reg      <= ncf_pkg::OUT_NONE;
      busy_cnt_reg <= 16'h0000;
    end else if (cmd_stb && cyc.data == ncf_pkg::CMD_STATUS &&
                 state_reg != ncf_pkg::ST_BUSY) begin
      out_reg <= ncf_pkg::OUT_STAT;
    end else if (cmd_stb && cyc.data == ncf_pkg::CMD_RESUME &&
                 state_reg != ncf_pkg::ST_BUSY) begin
      if (state_reg == ncf_pkg::ST_DATA) begin
        out_reg   <= ncf_pkg::OUT_FEAT;
        ridx_reg  <= 2'h0;
        rhalf_reg <= 1'b0;
      end
    end else if (cmd_stb && state_reg != ncf_pkg::ST_BUSY) begin
      // any time when ready, not only at power-up
      out_reg   <= ncf_pkg::OUT_NONE;
      cmd_reg   <= cyc.data;
      lun_reg   <= '0;
      pidx_reg  <= 2'h0;
      whalf_reg <= 1'b0;
      case (cyc.data)
        ncf_pkg::CMD_CAL_LONG, ncf_pkg::CMD_CAL_SHORT,
        ncf_pkg::CMD_SET_LUN, ncf_pkg::CMD_GET_LUN: begin
          state_reg <= ncf_pkg::ST_LUN;
        end
        ncf_pkg::CMD_SET_TGT, ncf_pkg::CMD_GET_TGT: begin
          state_reg <= ncf_pkg::ST_FA;
        end
        default: begin
          state_reg <= ncf_pkg::ST_IDLE;
        end
      endcase
    end else begin
      case (state_reg)
        ncf_pkg::ST_LUN: begin
          if (adr_stb && !lun_ok) begin
            state_reg <= ncf_pkg::ST_IDLE;
          end else if (adr_stb) begin
            lun_reg <= cyc.data[LUN_W-1:0];
            if (is_cal) begin
              state_reg    <= ncf_pkg::ST_BUSY;
              busy_cnt_reg <= go_long ? ncf_pkg::CAL_LONG_CYC
                                      : ncf_pkg::CAL_SHORT_CYC;
            end else begin
              state_reg <= ncf_pkg::ST_FA;
            end
          end
        end
        ncf_pkg::ST_FA: begin
          if (adr_stb) begin
            fa_reg <= cyc.data;
            if (is_get) begin
              state_reg    <= ncf_pkg::ST_BUSY;
              busy_cnt_reg <= ncf_pkg::FEAT_CYC;
            end else begin
              state_reg <= ncf_pkg::ST_PARAM;
            end
          end
        end
        ncf_pkg::ST_PARAM: begin
          if (dat_stb && skip_copy) begin
            whalf_reg <= 1'b0;
          end else if (dat_stb) begin
            whalf_reg <= ddr;
            pidx_reg  <= pidx_reg + 2'h1;
            if (pidx_reg != 2'h3) begin
              pbuf_reg[8*pidx_reg +: 8] <= cyc.data;
            end else begin
              state_reg    <= ncf_pkg::ST_BUSY;
              busy_cnt_reg <= (fa_reg == ncf_pkg::FA_TIMING) ?
                              ncf_pkg::ITC_CYC : ncf_pkg::FEAT_CYC;
            end
          end
        end
        ncf_pkg::ST_BUSY: begin
          busy_cnt_reg <= busy_cnt_reg - 16'h0001;
          if (busy_end) begin
            ridx_reg  <= 2'h0;
            rhalf_reg <= 1'b0;
            state_reg <= is_get ? ncf_pkg::ST_DATA : ncf_pkg::ST_IDLE;
            // a host that polled status must send the resume command
            if (is_get && out_reg != ncf_pkg::OUT_STAT) begin
              out_reg <= ncf_pkg::OUT_FEAT;
            end
          end
          // polling must not stall the timer; a poll that meets the
          // last busy cycle still leaves the host owing the resume
          if (cmd_stb && cyc.data == ncf_pkg::CMD_STATUS) begin
            out_reg <= ncf_pkg::OUT_STAT;
          end
        end
        ncf_pkg::ST_DATA: begin
          if (re_rise && out_reg == ncf_pkg::OUT_FEAT) begin
            if (ddr && !rhalf_reg) begin
              rhalf_reg <= 1'b1;
            end else begin
              rhalf_reg <= 1'b0;
              // past P4 the last byte repeats
              if (ridx_reg != 2'h3) begin
                ridx_reg <= ridx_reg + 2'h1;
              end
            end
          end
        end
        default: begin
          state_reg <= ncf_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // feature storage; volatile, zero at power-up
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      for (int l = 0; l < NUM_LUNS; l++) begin
        for (int f = 0; f < ncf_pkg::NUM_FEAT; f++) begin
          for (int b = 0; b < 4; b++) begin
            feat_mem[l][f][b] <= 8'h00;
          end
        end
      end
    end else if (feat_wr && fidx(fa_reg) != ncf_pkg::FIDX_NONE) begin
      for (int l = 0; l < NUM_LUNS; l++) begin
        // target command writes all LUNs, LUN command only its own
        if (cmd_reg == ncf_pkg::CMD_SET_TGT ||
            l == int'(lun_reg)) begin
          feat_mem[l][fidx(fa_reg)][0] <= pbuf_reg[7:0];
          feat_mem[l][fidx(fa_reg)][1] <= pbuf_reg[15:8];
          feat_mem[l][fidx(fa_reg)][2] <= pbuf_reg[23:16];
          feat_mem[l][fidx(fa_reg)][3] <= cyc.data;
        end
      end
    end
  end

  // ==========================================================
  // calibration control and impedance; a silent engine counts as failed
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      cal_on_reg <= 1'b0;
      got_reg    <= 1'b0;
      fail_reg   <= 1'b0;
      CAL_START  <= 1'b0;
      DRIVE_IMP  <= ncf_pkg::IMP_FACTORY;
    end else begin
      CAL_START <= go_cal;
      if (abort) begin
        if (cal_on_reg) begin
          DRIVE_IMP <= ncf_pkg::IMP_FACTORY;
        end
        cal_on_reg <= 1'b0;
      end else if (go_cal) begin
        cal_on_reg <= 1'b1;
        got_reg    <= 1'b0;
        fail_reg   <= 1'b0;
      end else if (cal_on_reg) begin
        if (CAL_DONE && !got_reg) begin
          got_reg   <= 1'b1;
          fail_reg  <= CAL_FAIL;
          DRIVE_IMP <= CAL_FAIL ? ncf_pkg::IMP_FALLBACK
                                : CAL_CODE;
        end else if (busy_end && !got_reg) begin
          fail_reg  <= 1'b1;
          DRIVE_IMP <= ncf_pkg::IMP_FALLBACK;
        end
        if (busy_end) begin
          cal_on_reg <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // pin drivers, all registered
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      DQ_OUT   <= 8'h00;
      DQ_OE    <= 1'b0;
      RB_N     <= 1'b1;
      CAL_BUSY <= 1'b0;
    end else begin
      DQ_OUT   <= (out_reg == ncf_pkg::OUT_STAT) ? status : rdata;
      DQ_OE    <= (out_reg != ncf_pkg::OUT_NONE) & ~cyc.cle & ~cyc.ale;
      RB_N     <= (state_reg != ncf_pkg::ST_BUSY);
      CAL_BUSY <= cal_on_reg;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!rst_n);

  sequence s_cal_go;   go_cal ##1 CAL_START; endsequence
  sequence s_cal_busy; (!RB_N && CAL_BUSY) [*3]; endsequence

  property p_cal_start;
    go_cal |=> CAL_START && cal_on_reg;
  endproperty
  a_cal_start: assert property (p_cal_start)
    else $error("calibration start not issued");

  property p_cal_busy;
    go_long && !abort |-> s_cal_go ##1 s_cal_busy;
  endproperty
  a_cal_busy: assert property (p_cal_busy)
    else $error("not busy during calibration");

  property p_window;
    busy_end && !abort |=> state_reg != ncf_pkg::ST_BUSY && !cal_on_reg;
  endproperty
  a_window: assert property (p_window)
    else $error("busy outlived its window");

  property p_converge;
    cal_on_reg && CAL_DONE && !CAL_FAIL && !got_reg && !abort && !go_cal
    |=> DRIVE_IMP == $past(CAL_CODE) && !fail_reg;
  endproperty
  a_converge: assert property (p_converge)
    else $error("calibrated code not applied");

  property p_fail;
    cal_on_reg && CAL_DONE && CAL_FAIL && !got_reg && !abort && !go_cal
    |=> fail_reg && DRIVE_IMP == ncf_pkg::IMP_FALLBACK ##2
        DQ_OUT[ncf_pkg::STAT_FAIL_BIT] ||
        $past(out_reg) != ncf_pkg::OUT_STAT;
  endproperty
  a_fail: assert property (p_fail)
    else $error("failure not reported or no fallback");

  property p_abort;
    abort && cal_on_reg |=> DRIVE_IMP == ncf_pkg::IMP_FACTORY
                            && !cal_on_reg ##1 RB_N;
  endproperty
  a_abort: assert property (p_abort)
    else $error("reset did not abort calibration");

  property p_ddr_skip;
    dat_stb && state_reg == ncf_pkg::ST_PARAM && skip_copy && !abort
    |=> pidx_reg == $past(pidx_reg) && !whalf_reg;
  endproperty
  a_ddr_skip: assert property (p_ddr_skip)
    else $error("second copy captured");

  property p_itc;
    feat_wr && fa_reg == ncf_pkg::FA_TIMING && !abort
    |=> busy_cnt_reg == ncf_pkg::ITC_CYC;
  endproperty
  a_itc: assert property (p_itc)
    else $error("timing mode write used wrong busy time");

  property p_resume;
    cmd_stb && cyc.data == ncf_pkg::CMD_RESUME &&
    state_reg == ncf_pkg::ST_DATA
    |=> out_reg == ncf_pkg::OUT_FEAT && ridx_reg == 2'h0;
  endproperty
  a_resume: assert property (p_resume)
    else $error("resume did not restart at first byte");

endmodule // ncf_top

// ### ncf_pkg.sv
// ncf_pkg: constants and types for the flash calibration/feature commands
package ncf_pkg;

  // ==========================================================
  // command codes taken on a command cycle
  localparam logic [7:0] CMD_CAL_LONG  = 8'hf9;
  localparam logic [7:0] CMD_CAL_SHORT = 8'hd9;
  localparam logic [7:0] CMD_SET_TGT   = 8'hef;
  localparam logic [7:0] CMD_SET_LUN   = 8'hd5;
  localparam logic [7:0] CMD_GET_TGT   = 8'hee;
  localparam logic [7:0] CMD_GET_LUN   = 8'hd4;
  localparam logic [7:0] CMD_STATUS    = 8'h70;
  localparam logic [7:0] CMD_RESUME    = 8'h00;
  localparam logic [7:0] CMD_RESET     = 8'hff;

  // ==========================================================
  // feature address bytes that hold storage
  localparam logic [7:0] FA_TIMING   = 8'h01;
  localparam logic [7:0] FA_DDR_CFG  = 8'h02;
  localparam logic [7:0] FA_DRIVE    = 8'h10;
  localparam logic [7:0] FA_TRAIN_A  = 8'h20;
  localparam logic [7:0] FA_TRAIN_B  = 8'h21;
  localparam logic [7:0] FA_VPP      = 8'h30;
  localparam logic [7:0] FA_VOLUME   = 8'h58;
  localparam int         NUM_FEAT    = 7;
  localparam logic [2:0] FIDX_NONE   = 3'h7;
  localparam logic [2:0] FIDX_TIMING = 3'h0;
  // data interface field of the timing mode feature, parameter byte 1
  localparam int         IFACE_LSB   = 4;

  // ==========================================================
  // status byte layout
  localparam int STAT_FAIL_BIT = 0;
  localparam int STAT_RDY_BIT  = 6;
  localparam int STAT_ARDY_BIT = 5;

  // ==========================================================
  // impedance after reset, and the fallback after a failed calibration
  localparam logic [7:0] IMP_FACTORY  = 8'h40;
  localparam logic [7:0] IMP_FALLBACK = 8'h44;

  // ==========================================================
  // busy windows: time in ns, cycles derived at the system clock rate
  localparam int CLK_MHZ      = 40;
  localparam int CAL_LONG_NS  = 1000;
  localparam int CAL_SHORT_NS = 400;
  localparam int FEAT_NS      = 1000;
  localparam int ITC_NS       = 1000;
  // longest windows, so round down, but never below one cycle
  function automatic logic [15:0] ns2cyc(input int ns);
    int c;
    c = (ns * CLK_MHZ) / 1000;
    return (c < 1) ? 16'h0001 : c[15:0];
  endfunction
  localparam logic [15:0] CAL_LONG_CYC  = ns2cyc(CAL_LONG_NS);
  localparam logic [15:0] CAL_SHORT_CYC = ns2cyc(CAL_SHORT_NS);
  localparam logic [15:0] FEAT_CYC      = ns2cyc(FEAT_NS);
  localparam logic [15:0] ITC_CYC       = ns2cyc(ITC_NS);

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_LUN   = 3'b001,
    ST_FA    = 3'b010,
    ST_PARAM = 3'b011,
    ST_BUSY  = 3'b100,
    ST_DATA  = 3'b101
  } ncf_state_type;

  typedef enum logic [1:0] {
    OUT_NONE = 2'b00,
    OUT_STAT = 2'b01,
    OUT_FEAT = 2'b10
  } ncf_out_type;

  // one sampled bus cycle
  typedef struct packed {
    logic       cle;
    logic       ale;
    logic [7:0] data;
  } ncf_cycle_type;

endpackage

// ### ncf_host_model.sv
// ncf_host_model: flash host that drives bus cycles from tasks
`timescale 1ns/1ps
module ncf_host_model (
  // clock and device answers
  input  wire logic       clk,
  input  wire logic [7:0] dq_out,
  input  wire logic       rb_n,
  // bus pins toward the device
  output logic            cle,
  output logic            ale,
  output logic            we_n,
  output logic            re_n,
  output logic      [7:0] dq
);
  logic ddr = 1'b0; // data sent twice, first read copy kept
  // all latches low and both strobes high from time zero
  initial begin
    {cle, ale, we_n, re_n, dq} = 12'h300;
  end
  // wait n edges, then land just past the last one
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // k is {cle, ale}; four cycles a level beats the three the sync needs
  task automatic put(input logic [1:0] k, input logic [7:0] d);
    int i;
    for (i = 0; i <= int'(ddr && k == 2'b00); i++) begin
      {cle, ale} = k;
      dq = d;
      we_n = 1'b0;
      step(4);
      we_n = 1'b1;
      step(4);
    end
  endtask
  // released data lines turn over, so a stale byte cannot match
  task automatic rd(output logic [7:0] b);
    int i;
    {cle, ale} = 2'b00;
    dq = ~dq;
    step(4);
    for (i = 0; i <= int'(ddr); i++) begin
      re_n = 1'b0;
      step(4);
      if (i == 0) b = dq_out;
      re_n = 1'b1;
      step(4);
    end
  endtask
  // the whole busy window runs out before anything else
  task automatic settle();
    step(6);
    for (int n = 0; n < 5000 && rb_n !== 1'b1; n++) step(1);
    step(2);
  endtask
endmodule // ncf_host_model

// ### ncf_top_test.sv
// ncf_top_test: self-checking bench for calibration and feature commands
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module ncf_top_test;
  localparam int MHZ     = ncf_pkg::CLK_MHZ;
  localparam int LONG_N  = ncf_pkg::CAL_LONG_NS * MHZ / 1000;
  localparam int SHORT_N = ncf_pkg::CAL_SHORT_NS * MHZ / 1000;
  localparam int FEAT_N  = ncf_pkg::FEAT_NS * MHZ / 1000;
  localparam int ITC_N   = ncf_pkg::ITC_NS * MHZ / 1000;
  // stored feature slots, then one vendor and one reserved address
  localparam logic [7:0] FAS [9] = '{8'h01, 8'h02, 8'h10, 8'h20, 8'h21,
                                     8'h30, 8'h58, 8'h62, 8'h03};
  logic       clk = 1'b0;
  logic       nrst = 1'b0;
  logic       cle, ale, we_n, re_n, dq_oe, rb_n, cal_start, cal_busy;
  logic [7:0] dq, dq_out, drive_imp, b;
  logic [7:0] eng_code = 8'h00;
  logic       eng_fail = 1'b0;
  logic       cal_done = 1'b0;
  int         eng_lat = 0, eng_cnt = -1, n_start = 0, low_n = 0;
  int         busy_len = 0, cyc = 0, n_fail = 0, n_compared = 0;
  // 40 MHz system clock
  always #12.5 clk = ~clk;
  ncf_top dut (
    .CLK_SYS(clk), .NRST(nrst), .CLE(cle), .ALE(ale), .WE_N(we_n),
    .RE_N(re_n), .DQ_IN(dq), .DQ_OUT(dq_out), .DQ_OE(dq_oe), .RB_N(rb_n),
    .CAL_START(cal_start), .CAL_DONE(cal_done),
    .CAL_FAIL(cal_done ? eng_fail : ~eng_fail),
    .CAL_CODE(cal_done ? eng_code : ~eng_code),
    .DRIVE_IMP(drive_imp), .CAL_BUSY(cal_busy));
  ncf_host_model host (.clk(clk), .dq_out(dq_out), .rb_n(rb_n), .cle(cle),
    .ale(ale), .we_n(we_n), .re_n(re_n), .dq(dq));
  // engine answers eng_lat+1 cycles after it sees a start; result lines garbled else
  always @(posedge clk) begin
    #1;
    cal_done = (eng_cnt == 0);
    if (cal_start === 1'b1) begin
      n_start++;
      eng_cnt = eng_lat;
    end else if (eng_cnt >= 0) begin
      eng_cnt--;
    end
  end
  // busy width kept at each rise of ready; a hang is cut short here
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (rb_n === 1'b0) begin
      low_n <= low_n + 1;
    end else if (low_n != 0) begin
      busy_len <= low_n;
      low_n <= 0;
    end
    if (cyc == 30000) begin
      n_fail++;
      $display("BAD cycle_limit exp %0d got %0d", 29999, cyc);
      conclude();
    end
  end
  task automatic conclude();
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // feature command; sets carry four bytes, gets leave data mode open
  task automatic feat(input logic [7:0] c, l, fa, input logic [31:0] p,
                      input bit wt);
    host.put(2'b10, c);
    if (c == 8'hd5 || c == 8'hd4) host.put(2'b01, l);
    host.put(2'b01, fa);
    for (int i = 3; i >= 0 && (c == 8'hef || c == 8'hd5); i--)
      host.put(2'b00, p[8*i +: 8]);
    if (wt) host.settle();
  endtask
  // all four bytes read before the next command is sent
  task automatic get4(input logic [31:0] e);
    for (int i = 3; i >= 0; i--) begin
      host.rd(b);
      `CHK("feature_byte", e[8*i +: 8], b)
    end
    `CHK("dq_oe", 1'b1, dq_oe)
  endtask
  task automatic t_reset();
    `CHK("drive_imp", 8'h40, drive_imp)
    `CHK("ready", 1'b1, rb_n)
    `CHK("cal_busy", 1'b0, cal_busy)
    `CHK("dq_oe_idle", 1'b0, dq_oe)
    feat(8'hee, 8'h00, 8'h01, 32'h0, 1'b1);
    get4(32'h0);
    $display("end of t_reset");
  endtask
  task automatic t_feat();
    logic [31:0] p;
    feat(8'hef, 8'h00, 8'h10, 32'h11223344, 1'b1);
    `CHK("feature_busy", FEAT_N, busy_len)
    feat(8'hee, 8'h00, 8'h10, 32'h0, 1'b1);
    get4(32'h11223344);
    for (int i = 0; i < 9; i++) begin
      p = {FAS[i], 8'hc3, 8'h5a, ~FAS[i]};
      feat(8'hd5, 8'h03, FAS[i], p, 1'b1);
      feat(8'hd4, 8'h03, FAS[i], 32'h0, 1'b1);
      get4(i < 7 ? p : 32'h0);
    end
    feat(8'hd4, 8'h01, 8'h20, 32'h0, 1'b1);
    get4(32'h0);
    $display("end of t_feat");
  endtask
  // status polled through the busy time, then output restarts at the top
  task automatic t_poll();
    feat(8'hee, 8'h00, 8'h10, 32'h0, 1'b0);
    host.put(2'b10, 8'h70);
    host.rd(b);
    `CHK("ready_in_busy", 1'b0, b[6])
    host.settle();
    host.rd(b);
    `CHK("ready_after", 2'b11, b[6:5])
    host.put(2'b10, 8'h00);
    get4(32'h11223344);
    $display("end of t_poll");
  endtask
  // one calibration with the engine primed; window and result checked
  task automatic cal(input logic [7:0] c, l, code, input logic f,
                     input int lat, n, input logic [7:0] imp);
    int s;
    s = n_start;
    {eng_code, eng_fail, eng_lat} = {code, f, lat};
    host.put(2'b10, c);
    host.put(2'b01, l);
    host.settle();
    `CHK("cal_started", s + 1, n_start)
    `CHK("cal_window", n, busy_len)
    `CHK("drive_imp", imp, drive_imp)
    host.put(2'b10, 8'h70);
    host.rd(b);
    `CHK("fail_bit", f, b[0])
  endtask
  task automatic t_cal();
    cal(8'hf9, 8'h00, 8'h5a, 1'b0, 5, LONG_N, 8'h5a);
    cal(8'hf9, 8'h02, 8'h77, 1'b1, 30, LONG_N, 8'h44);
    cal(8'hd9, 8'h01, 8'h66, 1'b0, 2, SHORT_N, 8'h66);
    cal(8'hd9, 8'h03, 8'h55, 1'b1, 10, SHORT_N, 8'h44);
    host.put(2'b10, 8'hd9);
    host.put(2'b01, 8'h04);
    host.settle();
    `CHK("lun_refused", 4, n_start)
    $display("end of t_cal");
  endtask
  // soft reset mid-run; the engine's late answer must not land
  task automatic t_abort();
    {eng_code, eng_fail, eng_lat} = {8'h5a, 1'b0, 32'd35};
    host.put(2'b10, 8'hf9);
    host.put(2'b01, 8'h00);
    `CHK("cal_busy_on", 1'b1, cal_busy)
    `CHK("busy_on", 1'b0, rb_n)
    host.put(2'b10, 8'hff);
    host.step(2);
    `CHK("abort_imp", 8'h40, drive_imp)
    `CHK("abort_ready", 1'b1, rb_n)
    host.step(45);
    `CHK("late_result", 8'h40, drive_imp)
    `CHK("abort_cal_busy", 1'b0, cal_busy)
    $display("end of t_abort");
  endtask
  task automatic t_ddr();
    feat(8'hef, 8'h00, 8'h01, 32'h10000000, 1'b1);
    `CHK("itc_busy", ITC_N, busy_len)
    host.ddr = 1'b1;
    feat(8'hef, 8'h00, 8'h10, 32'h0f1e2d3c, 1'b1);
    feat(8'hee, 8'h00, 8'h10, 32'h0, 1'b1);
    get4(32'h0f1e2d3c);
    $display("end of t_ddr");
  endtask
  // reset held four cycles, bus left alone until the sync has settled
  initial begin
    repeat (4) @(posedge clk);
    #1;
    nrst = 1'b1;
    host.step(6);
    t_reset();
    t_feat();
    t_poll();
    t_cal();
    t_abort();
    t_ddr();
    conclude();
  end
endmodule // ncf_top_test
